/* src/chop_cal_map.svh */
// register offsets, field positions and reset values of the chop and channel 0 bank
`ifndef CHOP_CAL_MAP_SVH
`define CHOP_CAL_MAP_SVH
// register indices; byte address is four times the index
`define IDX_CHOP_CFG 6'h06
`define IDX_SPARE_A 6'h07
`define IDX_SPARE_B 6'h08
`define IDX_CH0_SEL 6'h09
`define IDX_OFS_UP 6'h0a
`define IDX_OFS_LO 6'h0b
`define IDX_GAIN_UP 6'h0c
`define IDX_GAIN_LO 6'h0d
// reset values
`define RST_CHOP_CFG 16'h0600
`define RST_ZERO 16'h0000
`define RST_GAIN_UP 16'h8000
`define RST_CHOP_DLY 4'h3
`define RST_GAIN_WORD 24'h800000
// writable masks: read-only reserved bits stay zero
`define MASK_ALL 16'hffff
`define MASK_SPARE_B 16'hff0f
`define MASK_CH0_SEL 16'hffc7
`define MASK_LOWER 16'hff00
// field positions
`define CHOP_EN_BIT 8
`define CHOP_DLY_HI 12
`define CHOP_DLY_LO 9
`define SEL_HI 1
`define SEL_LO 0
`define LOW_BYTE_HI 15
`define LOW_BYTE_LO 8
`endif

/* src/chop_cal_pkg.sv */
// types shared by the chop and channel 0 calibration bank
package chop_cal_pkg;
  typedef enum logic [1:0] {
    src_external,
    src_shorted,
    src_test_pos,
    src_test_neg
  } input_src_t;
  typedef logic [15:0] reg_word_t;
endpackage

/* src/cfg_word.sv */
// one 16-bit configuration register with reset value and writable-bit mask
module cfg_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hffff
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [1:0] sel_i,
  // stored value
  output logic [15:0] value_o
);
  logic [15:0] lane_mask;
  logic [15:0] next_value;
  // byte lanes narrow the mask; masked-out bits keep their current value
  assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}} & WRITE_MASK;
  assign next_value = (value_o & ~lane_mask) | (wr_data_i & lane_mask);

  // register update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
    end else if (wr_en_i) begin
      value_o <= next_value;
    end
  end
endmodule

/* src/cal_assemble.sv */
// joins an upper word and the top byte of a lower word into a 24-bit value
`include "chop_cal_map.svh"
module cal_assemble #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register halves
  input wire logic [15:0] upper_i,
  input wire logic [15:0] lower_i,
  // registered assembled value
  output logic [WIDTH-1:0] word_o
);
  logic [WIDTH-1:0] next_word;
  assign next_word = {upper_i, lower_i[`LOW_BYTE_HI:`LOW_BYTE_LO]};

  // registered one cycle; upper and lower halves still change on separate writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_o <= {upper_i, 8'h00};
    end else begin
      word_o <= next_word;
    end
  end
endmodule

/* src/chop_cal_regs.sv */
// chop configuration and channel 0 input/calibration register bank on wishbone
`include "chop_cal_map.svh"
module chop_cal_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // chop control
  output logic chop_enable_bit_o,
  output logic [3:0] chop_delay_field_o,
  // channel 0 input routing
  output logic route_external_o,
  output logic route_shorted_o,
  output logic route_test_pos_o,
  output logic route_test_neg_o,
  // channel 0 calibration
  output logic signed [23:0] chan0_offset_o,
  output logic [23:0] chan0_gain_o
);
  localparam int NREG = 8;
  logic [15:0] regs [NREG];
  logic [NREG-1:0] hit;
  logic req;
  logic [5:0] idx;
  logic mapped;
  logic wr_fire;
  logic [15:0] rd_word;
  logic [23:0] ofs_word;
  logic [23:0] gain_word;
  chop_cal_pkg::input_src_t src;
  logic [15:0] rd_lane [NREG];
  logic [31:0] next_dat;
  logic next_ack;
  logic next_err;
  logic next_external;
  logic next_shorted;
  logic next_test_pos;
  logic next_test_neg;
  logic next_chop_en;
  logic [3:0] next_chop_dly;

  // a new request only when not already answering, so each access acks once
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign idx = adr_i[7:2];
  assign hit[0] = (idx == `IDX_CHOP_CFG);
  assign hit[1] = (idx == `IDX_SPARE_A);
  assign hit[2] = (idx == `IDX_SPARE_B);
  assign hit[3] = (idx == `IDX_CH0_SEL);
  assign hit[4] = (idx == `IDX_OFS_UP);
  assign hit[5] = (idx == `IDX_OFS_LO);
  assign hit[6] = (idx == `IDX_GAIN_UP);
  assign hit[7] = (idx == `IDX_GAIN_LO);
  assign mapped = |hit;
  assign wr_fire = req & we_i & mapped;

  // chop configuration: all bits writable, reset 0600h gives delay 0011b
  cfg_word #(.RESET_VALUE(`RST_CHOP_CFG), .WRITE_MASK(`MASK_ALL)) u_chop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[0]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[0])
  );
  // spare words keep whatever is written to their writable reserved bits
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_ALL)) u_spare_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[1]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[1])
  );
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_SPARE_B)) u_spare_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[2]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[2])
  );
  // bits 5:3 are read-only zero
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_CH0_SEL)) u_ch0_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[3]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[3])
  );
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_ALL)) u_ofs_up (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[4]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[4])
  );
  // low byte of the lower halves is read-only zero
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_LOWER)) u_ofs_lo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[5]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[5])
  );
  cfg_word #(.RESET_VALUE(`RST_GAIN_UP), .WRITE_MASK(`MASK_ALL)) u_gain_up (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[6]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[6])
  );
  cfg_word #(.RESET_VALUE(`RST_ZERO), .WRITE_MASK(`MASK_LOWER)) u_gain_lo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_fire & hit[7]),
    .wr_data_i(dat_i[15:0]),
    .sel_i(sel_i[1:0]),
    .value_o(regs[7])
  );

  // 24-bit words from the register pairs; registered one cycle, halves change on separate writes
  cal_assemble #(.WIDTH(24)) u_ofs_join (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .upper_i(regs[4]),
    .lower_i(regs[5]),
    .word_o(ofs_word)
  );
  cal_assemble #(.WIDTH(24)) u_gain_join (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .upper_i(regs[6]),
    .lower_i(regs[7]),
    .word_o(gain_word)
  );

  // read lanes: each register gated by its own hit, so or-ing the lanes selects
  generate
    for (genvar g = 0; g < NREG; g++) begin : g_lane
      assign rd_lane[g] = regs[g] & {16{hit[g]}};
    end
  endgenerate
  // an unmapped index leaves every lane zero, so the read word is zero too
  assign rd_word = rd_lane[0] | rd_lane[1] | rd_lane[2] | rd_lane[3] |
    rd_lane[4] | rd_lane[5] | rd_lane[6] | rd_lane[7];

  // next answer: ack for a mapped index, err otherwise; data only on a mapped read
  assign next_ack = req & mapped;
  assign next_err = req & ~mapped;
  assign next_dat = (req & ~we_i & mapped) ? {16'h0000, rd_word} : 32'h0000_0000;

  // bus answer: ack one cycle after request, err for unmapped index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      err_o <= next_err;
      dat_o <= next_dat;
    end
  end

  // input source decode
  assign src = chop_cal_pkg::input_src_t'(regs[3][`SEL_HI:`SEL_LO]);
  // the four codes are exhaustive, so exactly one routing flag is ever high
  assign next_external = (src == chop_cal_pkg::src_external);
  assign next_shorted = (src == chop_cal_pkg::src_shorted);
  assign next_test_pos = (src == chop_cal_pkg::src_test_pos);
  assign next_test_neg = (src == chop_cal_pkg::src_test_neg);
  assign next_chop_en = regs[0][`CHOP_EN_BIT];
  assign next_chop_dly = regs[0][`CHOP_DLY_HI:`CHOP_DLY_LO];

  // routing and control outputs, one-hot per source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_external_o <= 1'b1;
      route_shorted_o <= 1'b0;
      route_test_pos_o <= 1'b0;
      route_test_neg_o <= 1'b0;
      chop_enable_bit_o <= 1'b0;
      chop_delay_field_o <= `RST_CHOP_DLY;
    end else begin
      route_external_o <= next_external;
      route_shorted_o <= next_shorted;
      route_test_pos_o <= next_test_pos;
      route_test_neg_o <= next_test_neg;
      chop_enable_bit_o <= next_chop_en;
      chop_delay_field_o <= next_chop_dly;
    end
  end

  // calibration outputs: offset signed, gain unsigned q1.23 (0 to just under 2)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan0_offset_o <= 24'sh000000;
      chan0_gain_o <= `RST_GAIN_WORD;
    end else begin
      chan0_offset_o <= $signed(ofs_word);
      chan0_gain_o <= gain_word;
    end
  end
endmodule

/* testbench/chop_cal_checker.sv */
// concurrent checks on the chop and channel 0 bank ports
module chop_cal_checker (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // controls
  input wire logic chop_enable_bit_o,
  input wire logic [3:0] chop_delay_field_o,
  input wire logic route_external_o,
  input wire logic route_shorted_o,
  input wire logic route_test_pos_o,
  input wire logic route_test_neg_o,
  input wire logic signed [23:0] chan0_offset_o,
  input wire logic [23:0] chan0_gain_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is taken only while no answer is standing
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire mapped = adr_i[7:2] >= 6'h06 && adr_i[7:2] <= 6'h0d;
  a_ack_mapped: assert property (req && mapped |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  a_err_unmapped: assert property (req && !mapped |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_low_byte_zero: assert property (ack_o && !$past(we_i) &&
    $past(adr_i[7:2]) inside {6'h0b, 6'h0d} |-> dat_o[15:0] ==? 16'h??00)
    else $error("lower calibration low byte not zero");
  a_route_onehot: assert property ($onehot({route_external_o, route_shorted_o,
    route_test_pos_o, route_test_neg_o})) else $error("routing not one-hot");
  a_reset_cal: assert property ($fell(rst_i) |->
    chan0_gain_o == 24'h800000 && chan0_offset_o == 24'sh0) else $error("calibration reset");
  a_reset_chop: assert property ($fell(rst_i) |-> chop_delay_field_o == 4'h3 &&
    !chop_enable_bit_o && route_external_o) else $error("control reset");
endmodule

bind chop_cal_regs chop_cal_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .chop_enable_bit_o(chop_enable_bit_o), .chop_delay_field_o(chop_delay_field_o),
  .route_external_o(route_external_o), .route_shorted_o(route_shorted_o),
  .route_test_pos_o(route_test_pos_o), .route_test_neg_o(route_test_neg_o),
  .chan0_offset_o(chan0_offset_o), .chan0_gain_o(chan0_gain_o));

/* testbench/host_model.sv */
// wishbone master standing in for the host processor
module host_model (
  // clock and slave answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] dat_i,
  // request
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] dat_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one classic cycle; released address and data are inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [31:0] q, output logic e, output logic to);
    to = 1'b1;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h3;
    dat_o <= {16'h0, d};
    for (int i = 0; i < 16 && to; i++) begin
      @(posedge clk_i);
      if (ack_i || err_i) begin
        to = 1'b0;
        q = dat_i;
        e = err_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~{16'h0, d};
  endtask
endmodule

/* testbench/chop_cal_regs_tb.sv */
// self-checking bench for the chop and channel 0 bank
module chop_cal_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, err, en;
  logic [7:0] adr;
  logic [3:0] sel, dly, rt;
  logic [31:0] wd, rdat, q;
  logic signed [23:0] ofs;
  logic [23:0] gain;
  logic [15:0] rv[8] = '{16'h0600, 0, 0, 0, 0, 0, 16'h8000, 0};
  logic [7:0] wa[6] = '{8'h18, 8'h20, 8'h28, 8'h2c, 8'h30, 8'h34};
  logic [15:0] wv[6] = '{16'h1300, 16'h00f0, 16'h8001, 16'hfeff, 16'hffff, 16'hffff};
  logic [15:0] wx[6] = '{16'h1300, 16'h0000, 16'h8001, 16'hfe00, 16'hffff, 16'hff00};
  int num_errors = 0;
  int samples_checked = 0;
  always #20 clk_i = ~clk_i;
  host_model i_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  chop_cal_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .chop_enable_bit_o(en), .chop_delay_field_o(dly), .route_external_o(rt[0]),
    .route_shorted_o(rt[1]), .route_test_pos_o(rt[2]), .route_test_neg_o(rt[3]),
    .chan0_offset_o(ofs), .chan0_gain_o(gain));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access; a read also compares the data, every access the error flag
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic [15:0] e, input logic x);
    logic to, ge;
    i_host.xfer(w, a, d, q, ge, to);
    if (to) begin
      num_errors++;
      $display("[ERR] ack expected 1 seen 0");
      tally_and_finish();
    end else begin
      chk("err", {31'h0, ge}, {31'h0, x});
      if (!w) chk("read", q, {16'h0, e});
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) acc(0, 8'(8'h18 + 4 * i), 0, rv[i], 0);
    chk("dly", 32'(dly), 32'h3);
    chk("route", 32'(rt), 32'h1);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      acc(1, 8'h24, 16'(s), 0, 0);
      acc(0, 8'h24, 0, 16'(s), 0);
      chk("route", 32'(rt), 32'(1 << s));
    end
    acc(1, 8'h24, 16'h003b, 0, 0);
    acc(0, 8'h24, 0, 16'h0003, 0);
    $display("select test done");
    for (int i = 0; i < 6; i++) begin
      acc(1, wa[i], wv[i], 0, 0);
      acc(0, wa[i], 0, wx[i], 0);
    end
    chk("en", 32'(en), 32'h1);
    chk("dly", 32'(dly), 32'h9);
    chk("ofs", 32'(ofs), 32'hff80_01fe);
    chk("gain", 32'(gain), 32'h00ffffff);
    acc(1, 8'h18, 16'h0600, 0, 0);
    acc(1, 8'h3c, 16'h1234, 0, 1);
    acc(0, 8'h00, 0, 0, 1);
    chk("en", 32'(en), 32'h0);
    $display("calibration test done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("gain", 32'(gain), 32'h00800000);
    acc(0, 8'h28, 0, 16'h0000, 0);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
